// >>> core/output_fault_manager.sv
// Fault filtering, latching, protection and serial link of a
// sixteen-channel low-side switch. Analog comparator flags arrive
// asynchronously; the serial clock only runs inside chip-select frames.
//
// Contract
// - Frame shifts out fault word, then echoes first 24 bits received.
// - Last 24 bits held at chip-select rise are the command word.
// - Off-state open load judged per output only while commanded off.
// - Pull-down stays off until enabled; disabled only by host or sleep; here also cleared by either supply undervoltage.
// - Chip-select rise restarts fault delay; open load masked until done.
// - Open-load fault stays latched until read, output resumes normally.
// - Shutdown-disable 0, current limit with high drain: off after 450 us.
// - Thermal limit turns off that output only, then retry or latch-off.
// - Bit 23 set on current limit, short shutdown or thermal shutdown.
// - Logic supply undervoltage: all outputs off, control registers reset.
// - Load supply undervoltage: outputs shut down and reset applied.
// - Thermal shutdown of one output leaves others; bit 17 sets retry.
// - Bit 17 zero: stay off after cooling; one: retry once cooled.
// - Latched faults clear at chip-select rise; bits 15..0 per output.
// - Shutdown-disable 1: thermal protection only, no timed shutdown.
`default_nettype none
module output_fault_manager
    import fault_pkg::*;
#(
    parameter int unsigned FILT_CYC  = FILT_CYC_DOC,
    parameter int unsigned SHORT_CYC = SHORT_CYC_DOC
) (
    // System
    input  wire logic           sys_clk_i,
    input  wire logic           rst_i,
    // Serial link
    input  wire logic           sclk_i,
    input  wire logic           cs_n_i,
    input  wire logic           mosi_i,
    output var  logic           miso_o,
    // Analog fault flags
    input  wire logic [NCH-1:0] ol_cmp_i,
    input  wire logic [NCH-1:0] cur_lim_i,
    input  wire logic [NCH-1:0] vds_high_i,
    input  wire logic [NCH-1:0] therm_i,
    input  wire logic           uv_logic_i,
    input  wire logic           uv_load_i,
    // Drivers
    output var  logic [NCH-1:0] out_o,
    output var  logic [NCH-1:0] pd_en_o
);
    localparam int SW = 4 * NCH + 3;
    localparam logic [SW-1:0] SYNC_RST = {1'b1, {(SW-1){1'b0}}};

    // ------------------------------------------------------------------
    // Link domain
    // ------------------------------------------------------------------
    logic [4:0]        bit_cnt_q;
    logic [WORD_W-1:0] sr_q;
    logic [WORD_W-1:0] fw_q;
    logic              miso_q;

    // Frame signal itself clears the count, the clock may stop anytime
    always_ff @(posedge sclk_i or posedge cs_n_i) begin
        if (cs_n_i) begin
            bit_cnt_q <= BIT_CNT_RST;
        end else if (bit_cnt_q != ECHO_START) begin
            bit_cnt_q <= bit_cnt_q + 5'h01;
        end
    end

    always_ff @(posedge sclk_i) begin
        sr_q <= {sr_q[WORD_W-2:0], mosi_i};
    end

    // fw_q is frozen while the frame is open, so it crosses as a word
    // status first, then delayed echo
    always_ff @(posedge sclk_i or posedge cs_n_i) begin
        if (cs_n_i) begin
            miso_q <= 1'b0;
        end else if (bit_cnt_q != ECHO_START) begin
            miso_q <= fw_q[WORD_MSB - bit_cnt_q];
        end else begin
            miso_q <= sr_q[WORD_W-1];
        end
    end

    assign miso_o = miso_q;

    // ------------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------------
    logic [SW-1:0] raw;
    logic [SW-1:0] s1_q;
    logic [SW-1:0] s2_q;
    logic [SW-1:0] s3_q;
    logic [SW-1:0] in_q;
    logic [SW-1:0] agree;

    assign raw = {cs_n_i, uv_load_i, uv_logic_i, therm_i, vds_high_i,
                  cur_lim_i, ol_cmp_i};
    assign agree = ~(s2_q ^ s3_q);

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            s1_q <= SYNC_RST;
            s2_q <= SYNC_RST;
            s3_q <= SYNC_RST;
            in_q <= SYNC_RST;
        end else begin
            s1_q <= raw;
            s2_q <= s1_q;
            s3_q <= s2_q;
            in_q <= (agree & s3_q) | (~agree & in_q);
        end
    end

    logic [NCH-1:0] ol_s;
    logic [NCH-1:0] lim_s;
    logic [NCH-1:0] vds_s;
    logic [NCH-1:0] therm_s;
    logic           uv_logic_s;
    logic           uv_load_s;
    logic           cs_s;

    assign ol_s       = in_q[NCH-1:0];
    assign lim_s      = in_q[2*NCH-1:NCH];
    assign vds_s      = in_q[3*NCH-1:2*NCH];
    assign therm_s    = in_q[4*NCH-1:3*NCH];
    assign uv_logic_s = in_q[4*NCH];
    assign uv_load_s  = in_q[4*NCH+1];
    assign cs_s       = in_q[4*NCH+2];

    // ------------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------------
    logic           cs_prev_q;
    logic           cs_rise;
    logic [3:0]     op;
    logic           soft_rst;
    logic [NCH-1:0] on_cmd_q;
    logic [NCH-1:0] ol_en_q;
    logic [NCH-1:0] shdis_q;
    logic           retry_q;

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            cs_prev_q <= 1'b1;
        end else begin
            cs_prev_q <= cs_s;
        end
    end

    assign cs_rise = cs_s & ~cs_prev_q;
    assign op      = sr_q[OP_HI:OP_LO];
    assign soft_rst = uv_logic_s | uv_load_s | (cs_rise & (op == OP_RESET));

    // pull-down changes only by command or reset
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            on_cmd_q <= CH_RST;
            ol_en_q  <= CH_RST;
            shdis_q  <= CH_RST;
            retry_q  <= RETRY_RST;
        end else if (soft_rst) begin
            on_cmd_q <= CH_RST;
            ol_en_q  <= CH_RST;
            shdis_q  <= CH_RST;
            retry_q  <= RETRY_RST;
        end else if (cs_rise) begin
            case (op)
                OP_ONOFF:  on_cmd_q <= sr_q[DATA_HI:0];
                OP_OLEN:   ol_en_q  <= sr_q[DATA_HI:0];
                OP_GLOBAL: retry_q  <= sr_q[GL_THERM_BIT];
                OP_SHDIS:  shdis_q  <= sr_q[DATA_HI:0];
                default:   ;
            endcase
        end
    end

    assign pd_en_o = ol_en_q;

    // ------------------------------------------------------------------
    // Fault delay timer
    // ------------------------------------------------------------------
    logic [CNT_W-1:0] filt_cnt_q;
    logic             armed;

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            filt_cnt_q <= CNT_W'(FILT_CYC);
        end else if (cs_rise) begin
            filt_cnt_q <= CNT_W'(FILT_CYC);
        end else if (filt_cnt_q != '0) begin
            filt_cnt_q <= filt_cnt_q - 1'b1;
        end
    end

    assign armed = (filt_cnt_q == '0);

    // ------------------------------------------------------------------
    // Per-channel protection
    // ------------------------------------------------------------------
    logic [CNT_W-1:0] short_cnt_q [NCH];
    logic [NCH-1:0]   short_cond;
    logic [NCH-1:0]   short_trip;
    logic [NCH-1:0]   short_off_q;
    logic [NCH-1:0]   therm_off_q;
    logic [NCH-1:0]   out_q;
    logic [NCH-1:0]   ol_set;
    logic [NCH-1:0]   ch_set;
    logic [NCH-1:0]   flt_q;

    for (genvar i = 0; i < NCH; i++) begin : g_ch
        // timed short only when not disabled
        assign short_cond[i] = lim_s[i] & vds_s[i] & out_q[i] & ~shdis_q[i];
        assign short_trip[i] = short_cond[i] &
            (short_cnt_q[i] == CNT_W'(SHORT_CYC - 1));
        // open load only while commanded off
        assign ol_set[i] = ~on_cmd_q[i] & ol_en_q[i] & armed & ol_s[i];
        assign ch_set[i] = ol_set[i] | (lim_s[i] & out_q[i]) |
                           short_trip[i] | therm_s[i];

        always_ff @(posedge sys_clk_i or posedge rst_i) begin
            if (rst_i) begin
                short_cnt_q[i] <= '0;
            end else if (short_cond[i] & ~short_trip[i]) begin
                short_cnt_q[i] <= short_cnt_q[i] + 1'b1;
            end else begin
                short_cnt_q[i] <= '0;
            end
        end

        always_ff @(posedge sys_clk_i or posedge rst_i) begin
            if (rst_i) begin
                short_off_q[i] <= 1'b0;
            end else if (short_trip[i]) begin
                short_off_q[i] <= 1'b1;
            end else if (soft_rst | ~on_cmd_q[i] | shdis_q[i]) begin
                short_off_q[i] <= 1'b0;
            end
        end

        // retry or stay off after cooling
        always_ff @(posedge sys_clk_i or posedge rst_i) begin
            if (rst_i) begin
                therm_off_q[i] <= 1'b0;
            end else if (therm_s[i]) begin
                therm_off_q[i] <= 1'b1;
            end else if (soft_rst | retry_q | ~on_cmd_q[i]) begin
                therm_off_q[i] <= 1'b0;
            end
        end

        // gating uses this channel's state and the shared soft reset
        always_ff @(posedge sys_clk_i or posedge rst_i) begin
            if (rst_i) begin
                out_q[i] <= 1'b0;
            end else begin
                out_q[i] <= on_cmd_q[i] & ~therm_off_q[i] &
                            ~short_off_q[i] & ~soft_rst;
            end
        end

        // latched until frame end, set wins
        always_ff @(posedge sys_clk_i or posedge rst_i) begin
            if (rst_i) begin
                flt_q[i] <= 1'b0;
            end else if (ch_set[i]) begin
                flt_q[i] <= 1'b1;
            end else if (cs_rise) begin
                flt_q[i] <= 1'b0;
            end
        end
    end

    assign out_o = out_q;

    // ------------------------------------------------------------------
    // Global flag and response word
    // ------------------------------------------------------------------
    logic gflag_q;

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            gflag_q <= 1'b0;
        end else if (|ch_set) begin
            gflag_q <= 1'b1;
        end else if (cs_rise) begin
            gflag_q <= 1'b0;
        end
    end

    // Host must wait 400 ns after chip-select falls before clocking
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            fw_q <= '0;
        end else if (cs_s) begin
            fw_q <= {gflag_q, {(WORD_W-NCH-1){1'b0}}, flt_q};
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);

    a_echo_bit: assert property (
        @(posedge sclk_i) disable iff (cs_n_i)
        bit_cnt_q == ECHO_START |=> miso_q == $past(sr_q[WORD_W-1]))
        else $error("echo bit wrong");
    a_cmd_take: assert property (
        cs_rise && op == OP_ONOFF && !soft_rst
        |=> on_cmd_q == $past(sr_q[DATA_HI:0]))
        else $error("command not taken");
    a_ol_offonly: assert property (
        (ol_set & on_cmd_q) == '0)
        else $error("open load while on");
    a_pd_hold: assert property (
        !cs_rise && !soft_rst |=> $stable(pd_en_o))
        else $error("pull-down changed");
    a_filt_mask: assert property (
        cs_rise |=> (ol_set == '0) [*8])
        else $error("open load not masked");
    a_ol_latch: assert property (
        flt_q[0] && !cs_rise |=> flt_q[0])
        else $error("fault lost");
    a_short_cnt: assert property (
        $rose(short_off_q[0]) |-> $past(short_cond[0]) && !shdis_q[0])
        else $error("short off without cause");
    a_gflag_set: assert property (
        |(therm_s | short_trip)
        |=> gflag_q ##1 (fw_q[WORD_W-1] || !$past(cs_s)))
        else $error("global flag missing");
    a_uv_logic: assert property (
        uv_logic_s |=> on_cmd_q == '0 && ol_en_q == '0 && out_q == '0)
        else $error("logic uv not reset");
    a_uv_load: assert property (
        uv_load_s |=> out_q == '0)
        else $error("load uv output on");
    a_therm_off: assert property (
        therm_off_q[0] |=> !out_q[0])
        else $error("hot output on");
    a_latch_off: assert property (
        therm_off_q[0] && !retry_q && on_cmd_q[0] && !soft_rst
        |=> therm_off_q[0])
        else $error("latch-off released");
    a_clear_rise: assert property (
        cs_rise && ch_set == '0 |=> flt_q == '0 && !gflag_q)
        else $error("faults not cleared");
    a_shdis_skip: assert property (
        shdis_q[0] |=> !short_off_q[0])
        else $error("timed short when disabled");

    c_echo: cover property (@(posedge sclk_i) bit_cnt_q == ECHO_START);
    c_short: cover property (short_trip[0]);
    c_retry: cover property (retry_q && $fell(therm_off_q[0]));
    c_olflt: cover property (ol_set[0]);
endmodule
`default_nettype wire

// >>> inc/fault_pkg.sv
// Shared constants for the sixteen-channel output fault manager.
// Assumes a 10 MHz system clock and a 24-bit serial word, MSB first.
`default_nettype none
package fault_pkg;
    localparam int NCH         = 16;
    localparam int WORD_W      = 24;
    localparam int CNT_W       = 16;
    localparam int SYS_CLK_MHZ = 10;
    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int FILT_MIN_US   = 100;
    localparam int FILT_MAX_US   = 450;
    localparam int SHORT_US      = 450;
    localparam int FILT_CYC_DOC  = FILT_MIN_US * SYS_CLK_MHZ;
    localparam int SHORT_CYC_DOC = SHORT_US * SYS_CLK_MHZ;
    // ------------------------------------------------------------------
    // Word layout
    // ------------------------------------------------------------------
    localparam int OP_HI        = 23;
    localparam int OP_LO        = 20;
    localparam int DATA_HI      = 15;
    localparam int GL_THERM_BIT = 17;
    localparam logic [4:0] WORD_MSB   = 5'h17;
    localparam logic [4:0] ECHO_START = 5'h18;
    localparam logic [4:0] BIT_CNT_RST = 5'h00;
    // ------------------------------------------------------------------
    // Commands and reset values
    // ------------------------------------------------------------------
    localparam logic [3:0] OP_ONOFF  = 4'h0;
    localparam logic [3:0] OP_OLEN   = 4'h1;
    localparam logic [3:0] OP_GLOBAL = 4'h2;
    localparam logic [3:0] OP_SHDIS  = 4'h3;
    localparam logic [3:0] OP_RESET  = 4'hF;
    localparam logic [NCH-1:0] CH_RST    = 16'h0000;
    localparam logic           RETRY_RST = 1'b0;
endpackage
`default_nettype wire

// >>> bench/spi_host.sv
// Host model acting as the link master.
// Assumes the device samples on rising clock edges and launches there too.
`default_nettype none
module spi_host (
    output var  logic sclk_o,
    output var  logic cs_n_o,
    output var  logic mosi_o,
    input  wire logic miso_i
);
    timeunit 1ns;
    timeprecision 1ns;

    initial begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        mosi_o = 1'b0;
    end

    // one continuous frame
    // Clock period 30 ns; clock stands still outside frames
    task automatic xfer(input logic [47:0] tx, input int n,
                        output logic [47:0] rx);
        rx = '0;
        cs_n_o = 1'b0;
        #450;
        for (int i = n - 1; i >= 0; i--) begin
            mosi_o = tx[i];
            #15 sclk_o = 1'b1;
            #15 sclk_o = 1'b0;
            rx = {rx[46:0], miso_i};
        end
        #15 cs_n_o = 1'b1;
        // Released data line must not keep showing the last bit
        mosi_o = ~mosi_o;
        #600;
    endtask
endmodule
`default_nettype wire

// >>> bench/output_fault_manager_bench.sv
// Self-checking bench for the output fault manager.
// Assumes the host model in spi_host.sv and short delay parameters.
`default_nettype none
module output_fault_manager_bench import fault_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int FILT  = 40;
    localparam int SHORT = 30;
    typedef struct packed {
        logic [23:0] cmd;
        logic [15:0] out;
        logic [15:0] pd;
    } row_s;
    logic           sys_clk_i, rst_i, sclk, cs_n, mosi, miso;
    logic           uv_logic, uv_load;
    logic [NCH-1:0] ol_cmp, cur_lim, vds_high, therm, out, pd;
    int             n_errors = 0;
    int             checked  = 0;
    row_s           rows [8] = '{
        '{24'h00A5A5, 16'hA5A5, 16'h0000}, '{24'h1000FF, 16'hA5A5, 16'h00FF},
        '{24'h305555, 16'hA5A5, 16'h00FF}, '{24'h50FFFF, 16'hA5A5, 16'h00FF},
        '{24'h220000, 16'hA5A5, 16'h00FF}, '{24'h1000F0, 16'hA5A5, 16'h00F0},
        '{24'hF00000, 16'h0000, 16'h0000}, '{24'h00FFFF, 16'hFFFF, 16'h0000}};

    spi_host u_host (.sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi),
                     .miso_i(miso));
    output_fault_manager #(.FILT_CYC(FILT), .SHORT_CYC(SHORT)) u_dut (
        .sys_clk_i(sys_clk_i), .rst_i(rst_i), .sclk_i(sclk),
        .cs_n_i(cs_n), .mosi_i(mosi), .miso_o(miso), .ol_cmp_i(ol_cmp),
        .cur_lim_i(cur_lim), .vds_high_i(vds_high), .therm_i(therm),
        .uv_logic_i(uv_logic), .uv_load_i(uv_load), .out_o(out),
        .pd_en_o(pd));

    initial begin
        sys_clk_i = 1'b0;
        forever #50 sys_clk_i = ~sys_clk_i;
    end

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    task automatic chk_word(input string nm, input logic [23:0] e, g);
        checked++;
        if (g !== e) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk_out(input string nm, input logic [15:0] e, g);
        checked++;
        if (g !== e) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge sys_clk_i);
    endtask
    // One 24-bit frame, its fault word compared, then let it take effect
    task automatic frame(input logic [23:0] cmd, input logic [23:0] flt);
        logic [47:0] rx;
        u_host.xfer({24'h000000, cmd}, 24, rx);
        chk_word("fault word", flt, rx[23:0]);
        cyc(8);
    endtask
    task automatic give_verdict();
        $display("checked %0d n_errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Span covers the 27 frames plus the fault waits about ten times over
    initial begin
        #1ms;
        n_errors++;
        give_verdict();
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        logic [47:0] rx;
        rst_i = 1'b1;
        {uv_logic, uv_load} = 2'b00;
        {ol_cmp, cur_lim, vds_high, therm} = '0;
        cyc(12);
        rst_i = 1'b0;
        chk_out("reset outputs", 16'h0000, out);
        chk_out("reset pull-downs", 16'h0000, pd);
        u_host.xfer({24'h5A3C96, 24'h00F00F}, 48, rx);
        chk_word("status half", 24'h000000, rx[47:24]);
        chk_word("echo half", 24'h5A3C96, rx[23:0]);
        cyc(8);
        chk_out("second word", 16'hF00F, out);
        foreach (rows[i]) begin
            frame(rows[i].cmd, 24'h000000);
            chk_out("row outputs", rows[i].out, out);
            chk_out("row pull-downs", rows[i].pd, pd);
        end
        // Open load: only the output that is off may report
        frame(24'h1000FF, 24'h000000);
        frame(24'h000001, 24'h000000);
        ol_cmp = 16'h0009;
        cyc(FILT + 10);
        ol_cmp = 16'h0000;
        cyc(5);
        frame(24'h000001, 24'h800008);
        chk_out("resumed", 16'h0001, out);
        frame(24'h000001, 24'h000000);
        // Pulse inside the delay after a frame must stay unseen
        u_host.xfer(48'h0, 24, rx);
        @(negedge sys_clk_i);
        ol_cmp = 16'h0008;
        cyc(8);
        ol_cmp = 16'h0000;
        cyc(FILT + 10);
        frame(24'h000001, 24'h000000);
        // Timed short shutdown, with one output exempt
        frame(24'h300004, 24'h000000);
        frame(24'h000006, 24'h000000);
        {cur_lim, vds_high} = {16'h0006, 16'h0006};
        cyc(SHORT - 10);
        chk_out("before trip", 16'h0006, out);
        cyc(20);
        chk_out("after trip", 16'h0004, out);
        {cur_lim, vds_high} = '0;
        cyc(5);
        frame(24'h000000, 24'h800006);
        // Thermal latch-off, then retry
        frame(24'h000007, 24'h000000);
        therm = 16'h0004;
        cyc(10);
        chk_out("hot", 16'h0003, out);
        therm = 16'h0000;
        cyc(10);
        chk_out("cooled latched", 16'h0003, out);
        frame(24'h220000, 24'h800004);
        frame(24'h000003, 24'h000000);
        frame(24'h000007, 24'h000000);
        therm = 16'h0004;
        cyc(10);
        chk_out("hot again", 16'h0003, out);
        therm = 16'h0000;
        cyc(10);
        chk_out("cooled retry", 16'h0007, out);
        frame(24'h000007, 24'h800004);
        // Supply undervoltage
        frame(24'h1000FF, 24'h000000);
        uv_logic = 1'b1;
        cyc(10);
        chk_out("logic uv outputs", 16'h0000, out);
        chk_out("logic uv pull-downs", 16'h0000, pd);
        uv_logic = 1'b0;
        cyc(5);
        frame(24'h00000F, 24'h000000);
        uv_load = 1'b1;
        cyc(10);
        chk_out("load uv outputs", 16'h0000, out);
        uv_load = 1'b0;
        cyc(5);
        // Reset in mid-run clears outputs and pull-downs
        frame(24'h1000FF, 24'h000000);
        rst_i = 1'b1;
        cyc(2);
        rst_i = 1'b0;
        chk_out("mid reset outputs", 16'h0000, out);
        chk_out("mid reset pull-downs", 16'h0000, pd);
        frame(24'h000001, 24'h000000);
        chk_out("after mid reset", 16'h0001, out);
        give_verdict();
    end
endmodule
`default_nettype wire
